//--- src/aepb_params.svh
`ifndef AEPB_PARAMS_SVH
`define AEPB_PARAMS_SVH

// Widths of the peripheral bus
`define AEPB_ADDR_W 32
`define AEPB_DATA_W 32
`define AEPB_STRB_W 4

// Levels of the peripheral pins after reset
`define AEPB_CS_N_RST 1'b1
`define AEPB_ADS_RST 1'b0
`define AEPB_RNW_RST 1'b1
`define AEPB_RD_N_RST 1'b1
`define AEPB_WR_N_RST 1'b1
`define AEPB_BURST_RST 1'b0
`define AEPB_OE_RST 1'b0

// Encodings
`define AEPB_RNW_READ 1'b1
`define AEPB_RNW_WRITE 1'b0
`define AEPB_RESP_OKAY 2'h0
`define AEPB_LANES_ALL 4'hF

`endif

//--- src/aepb_pkg.sv
`include "aepb_params.svh"

package aepb_pkg;

  typedef struct packed {
    logic [`AEPB_ADDR_W-1:0] addr;
    logic [`AEPB_DATA_W-1:0] data;
    logic [`AEPB_STRB_W-1:0] lanes;
    logic rnw;
  } aepb_req_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_WACC = 3'b001,
    C_RACC = 3'b010,
    C_BUSY = 3'b011,
    C_BRESP = 3'b100,
    C_RRESP = 3'b101
  } aepb_core_st_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_ADDR = 2'b01,
    L_ACC = 2'b10,
    L_END = 2'b11
  } aepb_link_st_t;

endpackage

//--- src/aepb_bridge.sv
// Behaviour
// - Chip select is active low and high from reset until an access.
// - Muxed mode marks the address phase by a high strobe, low at reset.
// - Sync mode shows direction on a read-not-write pin, high at reset.
// - Async mode reads use an active-low read strobe, high at reset.
// - Async mode writes use an active-low write strobe, high at reset.
// - An active-high burst flag goes to the peripheral, low at reset.
// - No access completes until the peripheral ready input has been sampled high on two edges in a row.
// - Peripheral data is split in and out, with an output enable.
// - The peripheral address bus carries byte addresses at any width.
// - Per-byte lane enables pick the data lanes of an access.
// - The link uses the peripheral clock only if chosen and synchronous.
// - An AXI4-Lite slave port turns system accesses into link cycles.
// - Read-not-write high means read and low means write.
// - Byte lane enables are active high.
`timescale 1ns/100ps
`default_nettype none
`include "aepb_params.svh"

module aepb_bridge #(
  parameter bit SYNC_MODE = 1'b0,
  parameter bit MUX_MODE = 1'b0,
  parameter bit LINK_CLK_SEL = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic link_reset,
  input wire logic [`AEPB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`AEPB_DATA_W-1:0] s_axi_wdata,
  input wire logic [`AEPB_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AEPB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`AEPB_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ext_cs_n,
  output logic [`AEPB_ADDR_W-1:0] ext_addr,
  output logic ext_ads,
  output logic [`AEPB_STRB_W-1:0] ext_byte_lanes,
  output logic ext_rnw,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic ext_burst,
  input wire logic ext_rdy,
  input wire logic [`AEPB_DATA_W-1:0] ext_data_i,
  output logic [`AEPB_DATA_W-1:0] ext_data_o,
  output logic ext_data_oe
);
  import aepb_pkg::*;

  // System side, core_clk
  aepb_core_st_t state_ff;
  aepb_core_st_t nxt_state;
  aepb_req_t req_ff;
  aepb_req_t nxt_req;
  logic req_tgl_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic ack_s3_ff;
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  logic bvalid_ff;
  logic rvalid_ff;
  logic [1:0] bresp_ff;
  logic [1:0] rresp_ff;
  logic [`AEPB_DATA_W-1:0] rdata_ff;
  logic ack_tgl_ff;
  logic [`AEPB_DATA_W-1:0] lrdata_ff;

  wire logic wr_pair = s_axi_awvalid & s_axi_wvalid;
  wire logic take_wr = (state_ff == C_WACC);
  wire logic take_rd = (state_ff == C_RACC);
  // Link answer seen once both late stages agree
  wire logic ack_seen = (state_ff == C_BUSY) &&
    (ack_s2_ff == ack_s3_ff) && (ack_s3_ff == req_tgl_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      C_IDLE: begin
        // Writes win over reads when both are offered
        if (wr_pair) begin
          nxt_state = C_WACC;
        end else if (s_axi_arvalid) begin
          nxt_state = C_RACC;
        end
      end
      C_WACC: nxt_state = C_BUSY;
      C_RACC: nxt_state = C_BUSY;
      C_BUSY: begin
        if (ack_seen) begin
          nxt_state = req_ff.rnw ? C_RRESP : C_BRESP;
        end
      end
      C_BRESP: begin
        if (s_axi_bready) begin
          nxt_state = C_IDLE;
        end
      end
      C_RRESP: begin
        if (s_axi_rready) begin
          nxt_state = C_IDLE;
        end
      end
      default: nxt_state = C_IDLE;
    endcase
  end

  always_comb begin
    nxt_req = req_ff;
    if (take_wr) begin
      nxt_req.addr = s_axi_awaddr;
      nxt_req.data = s_axi_wdata;
      nxt_req.lanes = s_axi_wstrb;
      nxt_req.rnw = `AEPB_RNW_WRITE;
    end else if (take_rd) begin
      nxt_req.addr = s_axi_araddr;
      nxt_req.lanes = `AEPB_LANES_ALL;
      nxt_req.rnw = `AEPB_RNW_READ;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= C_IDLE;
      req_ff <= '0;
      req_tgl_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      req_tgl_ff <= req_tgl_ff ^ (take_wr | take_rd);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
    end
  end

  // Ready outputs high for exactly the accepting cycle; bvalid and rvalid held until bready or rready
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      bresp_ff <= `AEPB_RESP_OKAY;
      rresp_ff <= `AEPB_RESP_OKAY;
    end else begin
      awready_ff <= (nxt_state == C_WACC);
      wready_ff <= (nxt_state == C_WACC);
      arready_ff <= (nxt_state == C_RACC);
      bvalid_ff <= (nxt_state == C_BRESP);
      rvalid_ff <= (nxt_state == C_RRESP);
      bresp_ff <= `AEPB_RESP_OKAY;
      rresp_ff <= `AEPB_RESP_OKAY;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= '0;
    end else if (ack_seen && req_ff.rnw) begin
      rdata_ff <= lrdata_ff;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // Peripheral side
  // Link timed by the peripheral clock only when chosen and synchronous
  localparam bit USE_LINK = SYNC_MODE && LINK_CLK_SEL;
  wire logic epc_clk = USE_LINK ? link_clk : core_clk;
  wire logic epc_rst = USE_LINK ? link_reset : reset;

  aepb_link_st_t lstate_ff;
  aepb_link_st_t nxt_lstate;
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_s3_ff;
  logic rdy_s1_ff;
  logic rdy_s2_ff;
  logic rdy_s3_ff;
  logic ext_cs_n_ff;
  logic ext_ads_ff;
  logic ext_rnw_ff;
  logic ext_rd_n_ff;
  logic ext_wr_n_ff;
  logic ext_burst_ff;
  logic ext_oe_ff;
  logic [`AEPB_ADDR_W-1:0] ext_addr_ff;
  logic [`AEPB_STRB_W-1:0] ext_lanes_ff;
  logic [`AEPB_DATA_W-1:0] ext_dout_ff;

  // Payload in req_ff is stable from toggle until the answer returns
  wire logic req_new = (req_s2_ff == req_s3_ff) &&
    (req_s3_ff != ack_tgl_ff);
  wire logic rdy_ok = rdy_s2_ff & rdy_s3_ff;
  wire logic finish = (lstate_ff == L_ACC) && rdy_ok;
  wire logic go_addr = (nxt_lstate == L_ADDR);
  wire logic go_acc = (nxt_lstate == L_ACC);
  wire logic go_busy = go_addr | go_acc;
  wire logic go_rd = go_acc && req_ff.rnw;
  wire logic go_wr = go_acc && !req_ff.rnw;

  always_comb begin
    nxt_lstate = lstate_ff;
    case (lstate_ff)
      L_IDLE: begin
        if (req_new) begin
          nxt_lstate = MUX_MODE ? L_ADDR : L_ACC;
        end
      end
      L_ADDR: nxt_lstate = L_ACC;
      L_ACC: begin
        if (rdy_ok) begin
          nxt_lstate = L_END;
        end
      end
      L_END: nxt_lstate = L_IDLE;
      default: nxt_lstate = L_IDLE;
    endcase
  end

  always_ff @(posedge epc_clk or posedge epc_rst) begin
    if (epc_rst) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
      rdy_s3_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      rdy_s1_ff <= ext_rdy;
      rdy_s2_ff <= rdy_s1_ff;
      rdy_s3_ff <= rdy_s2_ff;
    end
  end

  always_ff @(posedge epc_clk or posedge epc_rst) begin
    if (epc_rst) begin
      lstate_ff <= L_IDLE;
      ack_tgl_ff <= 1'b0;
      lrdata_ff <= '0;
    end else begin
      lstate_ff <= nxt_lstate;
      ack_tgl_ff <= ack_tgl_ff ^ finish;
      if (finish && req_ff.rnw) begin
        lrdata_ff <= ext_data_i;
      end
    end
  end

  // Strobes derive from one direction bit, so never both low
  always_ff @(posedge epc_clk or posedge epc_rst) begin
    if (epc_rst) begin
      ext_cs_n_ff <= `AEPB_CS_N_RST;
      ext_ads_ff <= `AEPB_ADS_RST;
      ext_rnw_ff <= `AEPB_RNW_RST;
      ext_rd_n_ff <= `AEPB_RD_N_RST;
      ext_wr_n_ff <= `AEPB_WR_N_RST;
      ext_burst_ff <= `AEPB_BURST_RST;
      ext_oe_ff <= `AEPB_OE_RST;
    end else begin
      ext_cs_n_ff <= !go_busy;
      ext_ads_ff <= MUX_MODE && go_addr;
      ext_rnw_ff <= (SYNC_MODE && go_acc) ?
        req_ff.rnw : `AEPB_RNW_READ;
      ext_rd_n_ff <= !(!SYNC_MODE && go_rd);
      ext_wr_n_ff <= !(!SYNC_MODE && go_wr);
      // Single-beat AXI4-Lite never bursts
      ext_burst_ff <= `AEPB_BURST_RST;
      ext_oe_ff <= go_addr | go_wr;
    end
  end

  always_ff @(posedge epc_clk or posedge epc_rst) begin
    if (epc_rst) begin
      ext_addr_ff <= '0;
      ext_lanes_ff <= '0;
      ext_dout_ff <= '0;
    end else if (go_busy) begin
      ext_addr_ff <= req_ff.addr;
      ext_lanes_ff <= req_ff.lanes;
      ext_dout_ff <= go_addr ? req_ff.addr : req_ff.data;
    end
  end

  assign ext_cs_n = ext_cs_n_ff;
  assign ext_ads = ext_ads_ff;
  assign ext_rnw = ext_rnw_ff;
  assign ext_rd_n = ext_rd_n_ff;
  assign ext_wr_n = ext_wr_n_ff;
  assign ext_burst = ext_burst_ff;
  assign ext_data_oe = ext_oe_ff;
  assign ext_addr = ext_addr_ff;
  assign ext_byte_lanes = ext_lanes_ff;
  assign ext_data_o = ext_dout_ff;

endmodule

`default_nettype wire

//--- bench/aepb_checker.sv
`timescale 1ns/100ps
`default_nettype none
module aepb_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic link_reset,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic ext_cs_n,
  input wire logic ext_ads,
  input wire logic [3:0] ext_byte_lanes,
  input wire logic ext_rnw,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic ext_burst,
  input wire logic ext_rdy,
  input wire logic ext_data_oe
);
  AST_BURST_LOW: assert property (
    @(posedge link_clk) disable iff (link_reset)
    !ext_burst)
    else $error("burst flag raised");
  AST_ADS_LOW: assert property (
    @(posedge link_clk) disable iff (link_reset)
    !ext_ads)
    else $error("address strobe in plain mode");
  AST_STROBE_REST: assert property (
    @(posedge link_clk) disable iff (link_reset)
    ext_rd_n && ext_wr_n)
    else $error("async strobe low in sync mode");
  AST_RNW_REST: assert property (
    @(posedge link_clk) disable iff (link_reset)
    ext_cs_n |-> ext_rnw)
    else $error("direction not read while idle");
  AST_OE_WRITE: assert property (
    @(posedge link_clk) disable iff (link_reset)
    ext_data_oe |-> !ext_cs_n && !ext_rnw)
    else $error("drive outside write");
  AST_RDY_HOLD: assert property (
    @(posedge link_clk) disable iff (link_reset)
    (!ext_cs_n && !ext_rdy) [*3] |=> !ext_cs_n)
    else $error("ended unready");
  AST_RD_LANES: assert property (
    @(posedge link_clk) disable iff (link_reset)
    $fell(ext_cs_n) && ext_rnw |-> ext_byte_lanes == 4'hF)
    else $error("read lanes not all high");
  AST_CS_GAP: assert property (
    @(posedge link_clk) disable iff (link_reset)
    $rose(ext_cs_n) |=> ext_cs_n)
    else $error("no idle cycle");
  AST_BRESP_OK: assert property (
    @(posedge core_clk) disable iff (reset)
    s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("bad write response");
  AST_BVALID_HOLD: assert property (
    @(posedge core_clk) disable iff (reset)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid lost");
  CVR_WR: cover property (@(posedge link_clk) $fell(ext_cs_n) && !ext_rnw);
  CVR_RD: cover property (@(posedge link_clk) $fell(ext_cs_n) && ext_rnw);
  CVR_STALL: cover property (@(posedge link_clk)
    (!ext_cs_n && !ext_rdy) [*3]);
endmodule
bind aepb_bridge aepb_checker u_chk (.core_clk, .reset, .link_clk,
  .link_reset, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .ext_cs_n,
  .ext_ads, .ext_byte_lanes, .ext_rnw, .ext_rd_n, .ext_wr_n, .ext_burst,
  .ext_rdy, .ext_data_oe);
`default_nettype wire

//--- bench/aepb_periph.sv
`timescale 1ns/100ps
`default_nettype none
module aepb_periph (
  input wire logic link_clk,
  input wire logic link_reset,
  input wire logic ext_cs_n,
  input wire logic [31:0] ext_addr,
  input wire logic [3:0] ext_byte_lanes,
  input wire logic ext_rnw,
  input wire logic [31:0] ext_data_o,
  input wire logic ext_data_oe,
  input wire logic [3:0] stall,
  output logic ext_rdy,
  output logic [31:0] ext_data_i,
  output logic [31:0] last_addr
);
  logic [31:0] mem [16];
  logic [3:0] cnt;
  wire logic [3:0] idx = ext_addr[5:2];
  always @(posedge link_clk or posedge link_reset) begin
    if (link_reset) begin
      cnt <= 4'h0;
      ext_rdy <= 1'b0;
      ext_data_i <= 32'h0;
      last_addr <= 32'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
    end else begin
      cnt <= ext_cs_n ? 4'h0 : cnt + 4'(cnt != 4'hF);
      // Stall zero: ready registered, so high from the second selected cycle on
      ext_rdy <= !ext_cs_n && cnt >= stall;
      // Unselected bus shows the inverse of its last value
      ext_data_i <= (!ext_cs_n && ext_rnw) ? mem[idx] : ~ext_data_i;
      if (!ext_cs_n) last_addr <= ext_addr;
      if (!ext_cs_n && !ext_rnw && ext_data_oe)
        for (int i = 0; i < 4; i++)
          if (ext_byte_lanes[i]) mem[idx][8*i+:8] <= ext_data_o[8*i+:8];
    end
  end
endmodule
`default_nettype wire

//--- bench/aepb_bridge_tb.sv
`timescale 1ns/100ps
`default_nettype none
module aepb_bridge_tb;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0, stall = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ext_cs_n, ext_ads, ext_rnw, ext_rd_n, ext_wr_n;
  logic ext_burst, ext_rdy, ext_data_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, ext_addr, ext_data_i, ext_data_o, last_addr, v;
  logic [3:0] ext_byte_lanes;
  logic [31:0] exp_mem [16] = '{default: 32'h0};
  logic [3:0] lt [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'hF};
  int err_count = 0, n_tests = 0;
  always #50 core_clk = ~core_clk;
  initial #7 forever #16 link_clk = ~link_clk;
  aepb_bridge #(.SYNC_MODE(1'b1), .MUX_MODE(1'b0), .LINK_CLK_SEL(1'b1)) dut (
    .core_clk, .reset, .link_clk, .link_reset(reset),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_cs_n,
    .ext_addr, .ext_ads, .ext_byte_lanes, .ext_rnw, .ext_rd_n, .ext_wr_n,
    .ext_burst, .ext_rdy, .ext_data_i, .ext_data_o, .ext_data_oe);
  aepb_periph u_per (.link_clk, .link_reset(reset), .ext_cs_n, .ext_addr,
    .ext_byte_lanes, .ext_rnw, .ext_data_o, .ext_data_oe, .stall,
    .ext_rdy, .ext_data_i, .last_addr);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] mrg(input logic [31:0] o, d,
                                      input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i]) o[8*i+:8] = d[8*i+:8];
    return o;
  endfunction
  task automatic op(input logic [31:0] a, d, input logic [3:0] s);
    @(negedge core_clk);
    stall = 4'($urandom);
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_wstrb = s;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
    @(negedge core_clk);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    do @(posedge core_clk); while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'h0);
    @(negedge core_clk);
    s_axi_bready = 1'b0;
    chk(last_addr, a);
    exp_mem[a[5:2]] = mrg(exp_mem[a[5:2]], d, s);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    @(negedge core_clk);
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    do @(posedge core_clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'h0);
    @(negedge core_clk);
    s_axi_rready = 1'b0;
    chk(v, exp_mem[a[5:2]]);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(78));
    repeat (8) @(posedge core_clk);
    v = 32'({ext_cs_n, ext_ads, ext_rnw, ext_rd_n, ext_wr_n, ext_burst});
    chk(v, 32'h2E);
    @(negedge core_clk);
    reset = 1'b0;
    $display("reset levels test done");
    foreach (lt[i]) op(32'h14, $urandom, lt[i]);
    $display("lane corner test done");
    repeat (24) op($urandom & 32'h3C, $urandom, 4'($urandom));
    $display("random access test done");
    tally_and_finish;
  end
  initial begin
    #1000000;
    err_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
